//--- rtl/mmie_pkg.sv
package mmie_pkg;

    // instruction word fields, address map, widths and reset values
    localparam int          INSTR_W          = 16;
    localparam logic [6:0]  STORE_OPCODE     = 7'h37;
    localparam int          STORE_OP_MSB     = 15;
    localparam int          STORE_OP_LSB     = 9;
    localparam int          ACCESS_BIT       = 8;
    localparam logic [7:0]  MULT_OPCODE      = 8'h0d;
    localparam int          MULT_OP_MSB      = 15;
    localparam int          MULT_OP_LSB      = 8;
    localparam logic [7:0]  INDEXED_MAX_ADDR = 8'h5f;
    localparam logic [3:0]  ACCESS_BANK_LOW  = 4'h0;
    localparam logic [3:0]  ACCESS_BANK_HIGH = 4'hf;
    localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
    localparam logic [7:0]  WREG_RESET       = 8'h00;
    localparam logic [15:0] PRODUCT_RESET    = 16'h0000;
    localparam logic [1:0]  PHASE_RESET      = 2'h0;
    localparam logic [15:0] INSTR_RESET      = 16'h0000;
    localparam int          LITERAL_W        = 8;

    typedef enum logic [1:0]
    {
        MMIE_Q1 = 2'b00,
        MMIE_Q2 = 2'b01,
        MMIE_Q3 = 2'b10,
        MMIE_Q4 = 2'b11
    } mmie_phase_e;

    typedef struct packed
    {
        logic        en;
        logic        indexed;
        logic [11:0] addr;
        logic [7:0]  data;
    } mmie_file_write_s;

    typedef struct packed
    {
        logic [7:0] high;
        logic [7:0] low;
    } mmie_product_s;

endpackage

//--- rtl/mmie_product_reg.sv
`timescale 1ns/1ps
`default_nettype none
module mmie_product_reg
(
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire logic                   load,
    input  wire mmie_pkg::mmie_product_s next_product,
    output var  mmie_pkg::mmie_product_s product
);
    import mmie_pkg::*;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            product <= PRODUCT_RESET;
        else if (load)
            product <= next_product;
    end
endmodule
`default_nettype wire

//--- rtl/mmie_exec.sv
// How it works
// - store opcode writes working register to file
// - eight-bit file address field in word
// - access bit zero selects access bank
// - access bit one uses bank select register
// - access, extended, address <=95: indexed literal offset
// - multiply opcode: unsigned working times literal
// - product high and low bytes stored
// - no overflow or carry indication produced
// - zero product is never flagged
`timescale 1ns/1ps
`default_nettype none
module mmie_exec
(
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic [15:0]               instr,
    input  wire logic                      instr_valid,
    input  wire logic [7:0]                wreg_in,
    input  wire logic [3:0]                bank_select_register,
    input  wire logic                      extended_set_en,
    output logic      [1:0]                phase,
    output logic                           instr_done,
    output mmie_pkg::mmie_file_write_s     file_write,
    output mmie_pkg::mmie_product_s        product
);
    import mmie_pkg::*;

    mmie_phase_e      state;
    logic [15:0]      instr_q;
    logic             is_store;
    logic             is_mult;
    logic [7:0]       operand;
    logic [15:0]      result;
    logic [11:0]      next_addr;
    logic             next_indexed;
    logic             prod_load;
    mmie_product_s    next_product;
    logic             access_sel;
    logic [7:0]       file_field;
    logic [7:0]       mult_literal;
    // running sums of the shift-and-add array, one more entry than literal bits
    wire logic [15:0] partial_sum [LITERAL_W + 1];

    // refuse package edits that the decode slices or the multiplier array cannot serve
    if (STORE_OP_MSB != INSTR_W - 1 || MULT_OP_MSB != INSTR_W - 1)
    begin : g_bad_opcode_top
        $error("opcode fields must start at the top of the instruction word");
    end

    if (STORE_OP_MSB - STORE_OP_LSB + 1 != $bits(STORE_OPCODE) ||
        MULT_OP_MSB - MULT_OP_LSB + 1 != $bits(MULT_OPCODE))
    begin : g_bad_opcode_width
        $error("opcode slices must match the opcode constants in width");
    end

    if (ACCESS_BIT < LITERAL_W || ACCESS_BIT >= STORE_OP_LSB)
    begin : g_bad_access_bit
        $error("access select must sit between the file field and the store opcode");
    end

    if (INDEXED_MAX_ADDR >= ACCESS_SPLIT)
    begin : g_bad_split
        $error("indexed window must stay below the access bank split");
    end

    if ($bits(ACCESS_BANK_LOW) + LITERAL_W != $bits(next_addr))
    begin : g_bad_addr_width
        $error("bank bits and file field must fill the file address");
    end

    if (2 * LITERAL_W != $bits(mmie_product_s))
    begin : g_bad_product
        $error("product pair must be twice the literal width");
    end

    if ($bits(instr) != INSTR_W)
    begin : g_bad_instr_width
        $error("instruction port must match the instruction word width");
    end

    if ($bits(wreg_in) != LITERAL_W)
    begin : g_bad_wreg_width
        $error("working register must match the literal width");
    end

    // free-running phase counter; an instruction is latched at Q1
    always_ff @(posedge core_clk)
    begin
        if (reset)
            state <= MMIE_Q1;
        else
        begin
            unique case (state)
                MMIE_Q1: state <= MMIE_Q2;
                MMIE_Q2: state <= MMIE_Q3;
                MMIE_Q3: state <= MMIE_Q4;
                MMIE_Q4: state <= MMIE_Q1;
            endcase
        end
    end

    // phase has a flop of its own so the output never comes from decode logic
    always_ff @(posedge core_clk)
    begin
        if (reset)
            phase <= PHASE_RESET;
        else
            phase <= state + 2'h1;
    end

    // Q1 decode: the word is latched whole so later phases never look at the input
    always_ff @(posedge core_clk)
    begin
        if (reset)
            instr_q <= INSTR_RESET;
        else if (state == MMIE_Q1)
            instr_q <= instr;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            is_store <= 1'b0;
            is_mult  <= 1'b0;
        end
        else if (state == MMIE_Q1)
        begin
            is_store <= instr_valid && (instr[STORE_OP_MSB:STORE_OP_LSB] == STORE_OPCODE);
            is_mult  <= instr_valid && (instr[MULT_OP_MSB:MULT_OP_LSB] == MULT_OPCODE);
        end
    end

    // field views of the latched word; the file field and the literal share the low byte
    assign access_sel   = instr_q[ACCESS_BIT];
    assign file_field   = instr_q[LITERAL_W - 1:0];
    assign mult_literal = instr_q[LITERAL_W - 1:0];

    // Q2 operand read: working register sampled once, never written here
    always_ff @(posedge core_clk)
    begin
        if (reset)
            operand <= WREG_RESET;
        else if (state == MMIE_Q2)
            operand <= wreg_in;
    end

    // shift-and-add array, one row per literal bit; the top row is the finished product
    assign partial_sum[0] = 16'h0000;
    for (genvar b = 0; b < LITERAL_W; b++)
    begin : g_row
        assign partial_sum[b + 1] = partial_sum[b] + (mult_literal[b] ? (16'(operand) << b) : 16'h0000);
    end

    // Q3 process; 8x8 unsigned never exceeds 16 bits, so no carry is formed
    always_ff @(posedge core_clk)
    begin
        if (reset)
            result <= PRODUCT_RESET;
        else if (state == MMIE_Q3)
            result <= partial_sum[LITERAL_W];
    end

    // indexed mode only flags the write; the address is still reported in access-bank form
    always_comb
    begin
        next_indexed = 1'b0;
        if (!access_sel && extended_set_en && (file_field <= INDEXED_MAX_ADDR))
            next_indexed = 1'b1;
    end

    // low part of the access bank is core memory, the upper part is the special-function page
    always_comb
    begin
        if (access_sel)
            next_addr = {bank_select_register, file_field};
        else if (file_field < ACCESS_SPLIT)
            next_addr = {ACCESS_BANK_LOW, file_field};
        else
            next_addr = {ACCESS_BANK_HIGH, file_field};
    end

    // Q4 write back
    always_ff @(posedge core_clk)
    begin
        if (reset)
            file_write <= '0;
        else if (state == MMIE_Q4 && is_store)
        begin
            file_write.en      <= 1'b1;
            file_write.indexed <= next_indexed;
            file_write.addr    <= next_addr;
            file_write.data    <= operand;
        end
        else
            file_write.en <= 1'b0;
    end

    // done marks the cycle in which the write strobe or the new product is visible
    always_ff @(posedge core_clk)
    begin
        if (reset)
            instr_done <= 1'b0;
        else
            instr_done <= (state == MMIE_Q4) && (is_store || is_mult);
    end

    assign prod_load         = (state == MMIE_Q4) && is_mult;
    assign next_product.high = result[15:8];
    assign next_product.low  = result[7:0];

    // the product pair sits in its own register so it holds across every other instruction
    mmie_product_reg u_product
    (
        .core_clk     (core_clk),
        .reset        (reset),
        .load         (prod_load),
        .next_product (next_product),
        .product      (product)
    );
endmodule
`default_nettype wire

//--- verification/mmie_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
module mmie_exec_props
(
    input wire logic                       core_clk,
    input wire logic                       reset,
    input wire logic [15:0]                instr,
    input wire logic                       instr_valid,
    input wire logic [7:0]                 wreg_in,
    input wire logic [3:0]                 bank_select_register,
    input wire logic                       extended_set_en,
    input wire logic [1:0]                 phase,
    input wire logic                       instr_done,
    input wire mmie_pkg::mmie_file_write_s file_write,
    input wire mmie_pkg::mmie_product_s    product
);
    import mmie_pkg::*;
    logic [16:0] p1, p2, p3, p4;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // word taken at q1, lined up with the cycle its result shows
    always_ff @(posedge core_clk) {p4, p3, p2, p1} <= {p3, p2, p1, instr_valid, instr};
    sequence mult_seen;
        instr_done && p4[16] && p4[15:8] == MULT_OPCODE;
    endsequence
    a_done_pulse: assert property (instr_done |=> !instr_done) else $error("done");
    a_store_cause: assert property (file_write.en |-> p4[16] && p4[15:9] == STORE_OPCODE) else $error("cause");
    a_store_data: assert property (file_write.en |-> file_write.data == $past(wreg_in, 3)) else $error("data");
    a_bank_addr: assert property (file_write.en && p4[8] |->
        file_write.addr == {$past(bank_select_register), p4[7:0]}) else $error("bank");
    a_access_addr: assert property (file_write.en && !p4[8] |->
        file_write.addr == {p4[7:0] < 8'h60 ? 4'h0 : 4'hf, p4[7:0]}) else $error("access");
    a_indexed_mode: assert property (file_write.en |->
        file_write.indexed == (!p4[8] && $past(extended_set_en) && p4[7:0] <= 8'h5f)) else $error("indexed");
    a_mult_product: assert property (mult_seen |-> product == p4[7:0] * $past(wreg_in, 3)) else $error("product");
    a_product_hold: assert property ($changed(product) |-> mult_seen) else $error("hold");
    a_phase_step: assert property (!$past(reset) |-> phase == 2'($past(phase) + 2'h1)) else $error("phase");
    a_done_phase: assert property (instr_done |-> phase == 2'h0) else $error("done phase");
endmodule
bind mmie_exec mmie_exec_props u_props
(
    .core_clk             (core_clk),
    .reset                (reset),
    .instr                (instr),
    .instr_valid          (instr_valid),
    .wreg_in              (wreg_in),
    .bank_select_register (bank_select_register),
    .extended_set_en      (extended_set_en),
    .phase                (phase),
    .instr_done           (instr_done),
    .file_write           (file_write),
    .product              (product)
);
`default_nettype wire

//--- verification/move_and_multiply_instr_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module move_and_multiply_instr_exec_tb;
    import mmie_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, extended_set_en = 1'b0, instr_done;
    logic [15:0] instr = 16'h0;
    logic [7:0] wreg_in = 8'h0;
    logic [3:0] bank_select_register = 4'h0;
    logic [1:0] phase;
    mmie_file_write_s file_write;
    mmie_product_s product;
    int failures = 0, comparisons = 0;
    mmie_exec dut
    (
        .core_clk             (core_clk),
        .reset                (reset),
        .instr                (instr),
        .instr_valid          (instr_valid),
        .wreg_in              (wreg_in),
        .bank_select_register (bank_select_register),
        .extended_set_en      (extended_set_en),
        .phase                (phase),
        .instr_done           (instr_done),
        .file_write           (file_write),
        .product              (product)
    );
    task automatic check(input string name, input logic [23:0] seen, exp);
        comparisons++;
        failures += int'(seen !== exp);
        if (seen !== exp)
            $display("BAD %s expected %h seen %h", name, exp, seen);
    endtask
    task automatic stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic op(input logic [15:0] i, input logic [7:0] w, input logic [5:0] c);
        instr = i;
        wreg_in = w;
        {instr_valid, bank_select_register, extended_set_en} = c;
        repeat (2) @(posedge core_clk);
        #1 wreg_in = ~w;
        check("phase", phase, 2'h2);
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic t_reset();
        check("reset", {phase, instr_done, file_write.en, product}, 20'h0);
        $display("reset end");
    endtask
    task automatic t_store();
        op(16'h6fff, 8'h4f, 6'h35);
        check("write", file_write, {2'b10, 12'haff, 8'h4f});
        op(16'h6e5f, 8'h3c, 6'h35);
        check("write", file_write, {2'b11, 12'h05f, 8'h3c});
        op(16'h6e60, 8'h81, 6'h35);
        check("write", file_write, {2'b10, 12'hf60, 8'h81});
        op(16'h6e10, 8'h77, 6'h34);
        check("write", file_write, {2'b10, 12'h010, 8'h77});
        op(16'h6fff, 8'h11, 6'h15);
        check("refused", file_write, {2'b00, 12'h010, 8'h77});
        $display("store end");
    endtask
    task automatic t_mult();
        op(16'h0dc4, 8'he2, 6'h20);
        check("product", {file_write.en, product}, {1'b0, 16'had08});
        op(16'h0dff, 8'hff, 6'h20);
        check("product", {instr_done, product}, 17'h1fe01);
        op(16'h0d07, 8'h5a, 6'h00);
        check("idle", {instr_done, product}, 17'h0fe01);
        op(16'h0e12, 8'h5a, 6'h20);
        check("other", {instr_done, file_write.en, product}, 18'h0fe01);
        op(16'h0d00, 8'h5a, 6'h20);
        check("zero", {instr_done, product}, 17'h10000);
        $display("multiply end");
    endtask
    initial
        forever #5 core_clk = ~core_clk;
    initial
    begin
        #2000;
        failures++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        #1 reset = 1'b0;
        t_reset();
        t_store();
        t_mult();
        stop_test();
    end
endmodule
`default_nettype wire
